// >>> common/bcc_pkg.sv
// bcc_pkg: constants, types and shared functions of the calculator key control
// assumes a 200 MHz clock; values held as 8 unsigned bcd digits
package bcc_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int DIGIT_TIME_NS = 83000;
   localparam int DIGIT_CYC_DEF = DIGIT_TIME_NS / CLK_PERIOD_NS;
   localparam int DIGITS_PER_WORD = 9;
   localparam int ENTRY_WORDS = 9;
   localparam int RELEASE_WORDS = 16;
   localparam int CUTOFF_S = 35;
   localparam int CUTOFF_WORDS_DEF = (CUTOFF_S * 1000000) / ((DIGIT_TIME_NS / 1000) * DIGITS_PER_WORD);
   localparam logic [4:0] ENTRY_LAST = 5'(ENTRY_WORDS - 1);
   localparam logic [4:0] RELEASE_LAST = 5'(RELEASE_WORDS - 1);
   localparam logic [3:0] LAST_COL = 4'(DIGITS_PER_WORD - 1);
   localparam logic [3:0] MAX_DIGITS = 4'h8;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [8:0] ALL_POINTS = 9'h1_FF;
   // key code = column * 3 + row; digits 0..9 are codes 0..9
   localparam logic [4:0] KEY_DOT = 5'h0A;
   localparam logic [4:0] KEY_ADD = 5'h0B;
   localparam logic [4:0] KEY_MUL = 5'h0C;
   localparam logic [4:0] KEY_DIV = 5'h0D;
   localparam logic [4:0] KEY_EQU = 5'h0E;
   localparam logic [4:0] KEY_PCT = 5'h0F;
   localparam logic [4:0] KEY_CE = 5'h10;
   localparam logic [4:0] KEY_CLEAR_EVERYTHING = 5'h11;
   localparam logic [4:0] KEY_MPLUS = 5'h12;
   localparam logic [4:0] KEY_MEMORY_RECALL = 5'h13;
   localparam logic [4:0] KEY_EXPONENT = 5'h14;
   localparam logic [4:0] KEY_SINKING_FUND = 5'h15;

   typedef logic [31:0] bcc_word_t;
   typedef enum logic [1:0] {OP_MUL, OP_DIV, OP_PWR, OP_FIN} bcc_op_e;
   typedef enum logic [2:0] {MD_NONE, MD_CHAIN_MUL, MD_CHAIN_DIV, MD_CONST_MUL, MD_CONST_DIV} bcc_mode_e;

   // returns {carry, sum} of two 8-digit bcd words
   function automatic logic [32:0] bcc_bcd_add(input logic [31:0] a, input logic [31:0] b);
      logic [32:0] r;
      logic c;
      logic [4:0] s;
      r = '0;
      c = 1'b0;
      for (int i = 0; i < 8; i++) begin
         s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
         c = (s > 5'h09);
         if (c) begin
            s = s + 5'h06;
         end
         r[i*4 +: 4] = s[3:0];
      end
      r[32] = c;
      return r;
   endfunction : bcc_bcd_add
endpackage : bcc_pkg

// >>> common/bcc_time_if.sv
// bcc_time_if: scan and word timing passed from the timebase to the control
// assumes one clock; all strobes are one-cycle pulses
`timescale 1ns/100ps
interface bcc_time_if;
   logic digit_stb;
   logic word_tick;
   logic sample_tick;
   logic [3:0] scan_col;
   modport src (output digit_stb, output word_tick, output sample_tick, output scan_col);
   modport snk (input digit_stb, input word_tick, input sample_tick, input scan_col);
endinterface : bcc_time_if

// >>> hdl/bcc_key_control.sv
// bcc_key_control: key debounce, ready status, key interpretation, error and display cutoff
// assumes key lines synchronous to clk; multiply, divide and financial math done outside
`timescale 1ns/100ps
module bcc_key_control
   import bcc_pkg::*;
#(
   parameter int DIGIT_CYC = DIGIT_CYC_DEF,
   parameter int CUTOFF_WORDS = CUTOFF_WORDS_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic key_return_line_one,
   input wire logic key_return_line_three,
   input wire logic key_return_line_four,
   input wire logic op_done,
   input wire logic op_overflow,
   input wire logic op_neg_base,
   input wire logic [31:0] op_result,
   output logic [3:0] scan_col,
   output logic ready,
   output logic op_req,
   output logic [1:0] op_kind,
   output logic [31:0] op_a,
   output logic [31:0] op_b,
   output logic [31:0] disp_digits,
   output logic [8:0] disp_points,
   output logic disp_blank,
   output logic err_flag
);
   typedef enum logic [2:0] {KS_IDLE, KS_ENTRY, KS_EXEC, KS_HELD, KS_RELEASE} bcc_state_e;

   typedef struct packed {
      bcc_state_e st;
      logic [4:0] cnt;
      logic [4:0] key_code;
      logic [1:0] key_row;
      logic [3:0] key_col;
      logic key_lvl;
      bcc_word_t x;
      bcc_word_t y;
      bcc_word_t a;
      bcc_word_t m;
      bcc_word_t n;
      bcc_word_t i;
      logic [3:0] dp_pos;
      logic dp_set;
      logic [3:0] ndig;
      logic entering;
      logic last_num;
      logic last_addsub;
      bcc_mode_e mode;
      bcc_mode_e pend_mode;
      logic pend_y_res;
      logic pend_y_x;
      logic pend_clr_a;
      logic op_req;
      bcc_op_e op_kind;
      bcc_word_t op_a;
      bcc_word_t op_b;
      logic err;
      logic [23:0] cut_cnt;
      logic blank;
      logic ready;
      logic [3:0] scan_col;
      bcc_word_t disp_digits;
      logic [8:0] disp_points;
   } bcc_ctl_s;

   localparam logic [23:0] CUTOFF_LAST = 24'(CUTOFF_WORDS - 1);

   bcc_time_if tif ();

   bcc_timebase #(
      .DIGIT_CYC(DIGIT_CYC)
   ) u_timebase (
      .clk(clk),
      .rst_n(rst_n),
      .tb(tif.src)
   );

   bcc_ctl_s c_reg;
   bcc_ctl_s c_next;
   logic [2:0] lines;
   logic [32:0] add_sum;
   logic [32:0] mem_sum;

   assign lines = {key_return_line_four, key_return_line_three, key_return_line_one};
   assign add_sum = bcc_bcd_add(c_reg.x, c_reg.a);
   assign mem_sum = bcc_bcd_add(c_reg.m, c_reg.x);

   always_comb begin
      c_next = c_reg;
      c_next.scan_col = tif.scan_col;
      // keyboard sees the registered column, one cycle behind the timebase
      if (tif.digit_stb && c_reg.st != KS_IDLE && c_reg.scan_col == c_reg.key_col) begin
         c_next.key_lvl = lines[c_reg.key_row];
      end

      case (c_reg.st)
         KS_IDLE: begin
            c_next.ready = 1'b1;
            if (tif.digit_stb && |lines) begin
               c_next.key_col = c_reg.scan_col;
               c_next.key_row = lines[0] ? 2'd0 : (lines[1] ? 2'd1 : 2'd2);
               c_next.key_code = 5'({1'b0, c_reg.scan_col} * 5'd3) + (lines[0] ? 5'd0 : (lines[1] ? 5'd1 : 5'd2));
               c_next.key_lvl = 1'b1;
               c_next.cnt = '0;
               c_next.st = KS_ENTRY;
            end
         end
         KS_ENTRY: begin
            c_next.ready = 1'b1;
            if (tif.sample_tick && !c_reg.key_lvl) begin
               c_next.cnt = '0;
               c_next.st = KS_IDLE;
            end else if (tif.word_tick) begin
               if (c_reg.cnt == ENTRY_LAST) begin
                  c_next.ready = 1'b0;
                  c_next.st = KS_HELD;
                  c_next.cut_cnt = '0;
                  c_next.blank = 1'b0;
                  if (c_reg.err) begin
                     c_next.err = 1'b0;
                  end else begin
                     case (c_reg.key_code)
                        KEY_DOT: begin
                           if (!c_reg.entering) begin
                              if (c_reg.last_addsub) begin
                                 c_next.a = c_reg.x;
                              end
                              c_next.x = REG_RESET;
                              c_next.ndig = '0;
                              c_next.entering = 1'b1;
                           end
                           c_next.dp_pos = c_next.entering ? c_next.ndig : 4'h0;
                           c_next.dp_set = 1'b1;
                           c_next.last_num = 1'b1;
                           c_next.last_addsub = 1'b0;
                        end
                        KEY_ADD: begin
                           if (add_sum[32]) begin
                              c_next.a = c_reg.x;
                              c_next.x = REG_RESET;
                              c_next.err = 1'b1;
                           end else begin
                              if (!c_reg.last_addsub) begin
                                 c_next.a = c_reg.x;
                              end
                              c_next.x = add_sum[31:0];
                           end
                           c_next.last_addsub = 1'b1;
                           c_next.entering = 1'b0;
                           c_next.dp_set = 1'b0;
                           c_next.last_num = 1'b0;
                        end
                        KEY_MUL, KEY_DIV: begin
                           if (c_reg.mode == MD_CHAIN_MUL || c_reg.mode == MD_CHAIN_DIV) begin
                              c_next.op_req = 1'b1;
                              c_next.op_kind = (c_reg.mode == MD_CHAIN_MUL) ? OP_MUL : OP_DIV;
                              c_next.op_a = c_reg.y;
                              c_next.op_b = c_reg.x;
                              c_next.pend_y_res = 1'b1;
                              c_next.st = KS_EXEC;
                           end else begin
                              c_next.y = c_reg.x;
                           end
                           c_next.mode = (c_reg.key_code == KEY_MUL) ? MD_CHAIN_MUL : MD_CHAIN_DIV;
                           c_next.pend_mode = c_next.mode;
                           c_next.entering = 1'b0;
                           c_next.last_num = 1'b0;
                           c_next.last_addsub = 1'b0;
                        end
                        KEY_EQU, KEY_PCT: begin
                           if (c_reg.key_code == KEY_PCT) begin
                              c_next.a = c_reg.x;
                           end
                           if (c_reg.mode != MD_NONE) begin
                              c_next.op_req = 1'b1;
                              c_next.st = KS_EXEC;
                              c_next.op_kind = (c_reg.mode == MD_CHAIN_MUL || c_reg.mode == MD_CONST_MUL) ? OP_MUL : OP_DIV;
                              c_next.op_a = (c_reg.mode == MD_CHAIN_DIV) ? c_reg.y : c_reg.x;
                              c_next.op_b = (c_reg.mode == MD_CHAIN_DIV) ? c_reg.x : c_reg.y;
                              // divide keeps its second factor as the constant
                              c_next.pend_y_x = (c_reg.mode == MD_CHAIN_DIV);
                              c_next.pend_mode = (c_reg.mode == MD_CHAIN_MUL || c_reg.mode == MD_CONST_MUL) ?
                                 MD_CONST_MUL : MD_CONST_DIV;
                           end
                           c_next.entering = 1'b0;
                           c_next.last_num = 1'b0;
                           c_next.last_addsub = 1'b0;
                        end
                        KEY_CE: begin
                           c_next.x = REG_RESET;
                           if (!c_reg.last_num) begin
                              c_next.y = REG_RESET;
                              c_next.a = REG_RESET;
                           end
                           c_next.entering = 1'b0;
                           c_next.dp_set = 1'b0;
                           c_next.last_num = 1'b0;
                           c_next.last_addsub = 1'b0;
                        end
                        KEY_CLEAR_EVERYTHING: begin
                           c_next.x = REG_RESET;
                           c_next.y = REG_RESET;
                           c_next.a = REG_RESET;
                           c_next.m = REG_RESET;
                           c_next.n = REG_RESET;
                           c_next.i = REG_RESET;
                           c_next.mode = MD_NONE;
                           c_next.entering = 1'b0;
                           c_next.dp_set = 1'b0;
                           c_next.last_num = 1'b0;
                           c_next.last_addsub = 1'b0;
                        end
                        KEY_MPLUS: begin
                           if (mem_sum[32]) begin
                              c_next.m = REG_RESET;
                              c_next.x = REG_RESET;
                              c_next.err = 1'b1;
                           end else begin
                              c_next.m = mem_sum[31:0];
                           end
                           c_next.entering = 1'b0;
                           c_next.last_num = 1'b0;
                        end
                        KEY_MEMORY_RECALL: begin
                           c_next.x = c_reg.m;
                           c_next.entering = 1'b0;
                           c_next.dp_set = 1'b0;
                           c_next.last_num = 1'b1;
                           c_next.last_addsub = 1'b0;
                        end
                        KEY_EXPONENT, KEY_SINKING_FUND: begin
                           c_next.op_req = 1'b1;
                           c_next.op_kind = (c_reg.key_code == KEY_EXPONENT) ? OP_PWR : OP_FIN;
                           c_next.op_a = c_reg.y;
                           c_next.op_b = c_reg.x;
                           c_next.pend_clr_a = 1'b1;
                           c_next.pend_mode = MD_CONST_MUL;
                           c_next.st = KS_EXEC;
                           c_next.entering = 1'b0;
                           c_next.last_num = 1'b0;
                           c_next.last_addsub = 1'b0;
                        end
                        default: begin
                           if (c_reg.key_code <= 5'h09) begin
                              if (!c_reg.entering) begin
                                 if (c_reg.last_addsub) begin
                                    c_next.a = c_reg.x;
                                 end
                                 c_next.x = {28'h000_0000, c_reg.key_code[3:0]};
                                 c_next.ndig = 4'h1;
                                 c_next.dp_set = 1'b0;
                                 c_next.entering = 1'b1;
                              end else if (c_reg.ndig < MAX_DIGITS) begin
                                 c_next.x = {c_reg.x[27:0], c_reg.key_code[3:0]};
                                 c_next.ndig = c_reg.ndig + 4'h1;
                              end
                              c_next.last_num = 1'b1;
                           end else begin
                              c_next.entering = 1'b0;
                              c_next.last_num = 1'b0;
                           end
                           c_next.last_addsub = 1'b0;
                        end
                     endcase
                  end
               end else begin
                  c_next.cnt = c_reg.cnt + 5'h01;
               end
            end
         end
         KS_EXEC: begin
            c_next.ready = 1'b0;
            c_next.op_req = 1'b0;
            if (op_done) begin
               c_next.st = KS_HELD;
               c_next.pend_y_res = 1'b0;
               c_next.pend_y_x = 1'b0;
               c_next.pend_clr_a = 1'b0;
               if (op_neg_base && c_reg.op_kind == OP_PWR) begin
                  c_next.err = 1'b1;
                  c_next.y = c_reg.x;
                  c_next.x = REG_RESET;
               end else if (op_overflow) begin
                  c_next.err = 1'b1;
                  c_next.x = REG_RESET;
                  if (c_reg.op_kind == OP_PWR || c_reg.op_kind == OP_FIN) begin
                     c_next.n = op_result;
                     c_next.i = op_result;
                     c_next.a = op_result;
                  end
               end else begin
                  c_next.x = op_result;
                  c_next.mode = c_reg.pend_mode;
                  if (c_reg.pend_y_res) begin
                     c_next.y = op_result;
                  end
                  if (c_reg.pend_y_x) begin
                     c_next.y = c_reg.x;
                  end
                  if (c_reg.pend_clr_a) begin
                     c_next.a = REG_RESET;
                  end
               end
            end
         end
         KS_HELD: begin
            c_next.ready = 1'b0;
            if (tif.sample_tick && !c_reg.key_lvl) begin
               c_next.cnt = '0;
               c_next.st = KS_RELEASE;
            end
         end
         KS_RELEASE: begin
            c_next.ready = 1'b0;
            if (tif.sample_tick && c_reg.key_lvl) begin
               c_next.cnt = '0;
               c_next.st = KS_HELD;
            end else if (tif.word_tick) begin
               if (c_reg.cnt == RELEASE_LAST) begin
                  c_next.st = KS_IDLE;
                  c_next.ready = 1'b1;
               end else begin
                  c_next.cnt = c_reg.cnt + 5'h01;
               end
            end
         end
         default: begin
            c_next.st = KS_IDLE;
         end
      endcase

      if (tif.word_tick && c_next.cut_cnt == c_reg.cut_cnt) begin
         if (c_reg.cut_cnt == CUTOFF_LAST) begin
            c_next.blank = 1'b1;
         end else begin
            c_next.cut_cnt = c_reg.cut_cnt + 24'h00_0001;
         end
      end

      if (c_next.err) begin
         c_next.disp_digits = REG_RESET;
         c_next.disp_points = ALL_POINTS;
      end else if (c_next.blank) begin
         c_next.disp_digits = REG_RESET;
         c_next.disp_points = ALL_POINTS;
      end else begin
         c_next.disp_digits = c_next.x;
         c_next.disp_points = c_next.dp_set ? (9'h0_01 << c_next.dp_pos) : 9'h0_00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c_reg <= '0;
         c_reg.ready <= 1'b1;
      end else begin
         c_reg <= c_next;
      end
   end

   assign scan_col = c_reg.scan_col;
   assign ready = c_reg.ready;
   assign op_req = c_reg.op_req;
   assign op_kind = c_reg.op_kind;
   assign op_a = c_reg.op_a;
   assign op_b = c_reg.op_b;
   assign disp_digits = c_reg.disp_digits;
   assign disp_points = c_reg.disp_points;
   assign disp_blank = c_reg.blank;
   assign err_flag = c_reg.err;
endmodule : bcc_key_control

// >>> hdl/bcc_timebase.sv
// bcc_timebase: digit strobe, scan column, word tick and every-other-word sample tick
// assumes clk at 200 MHz and active-low asynchronous reset
`timescale 1ns/100ps
module bcc_timebase
   import bcc_pkg::*;
#(
   parameter int DIGIT_CYC = DIGIT_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   bcc_time_if.src tb
);
   typedef struct packed {
      logic [23:0] cnt;
      logic [3:0] col;
      logic phase;
      logic digit_stb;
      logic word_tick;
      logic sample_tick;
   } bcc_tb_s;

   localparam logic [23:0] DIGIT_LAST = 24'(DIGIT_CYC - 1);

   bcc_tb_s tb_reg;
   bcc_tb_s tb_next;

   always_comb begin
      tb_next = tb_reg;
      tb_next.digit_stb = 1'b0;
      tb_next.word_tick = 1'b0;
      tb_next.sample_tick = 1'b0;
      if (tb_reg.cnt == DIGIT_LAST) begin
         tb_next.cnt = '0;
         tb_next.digit_stb = 1'b1;
         if (tb_reg.col == LAST_COL) begin
            tb_next.col = '0;
            tb_next.word_tick = 1'b1;
            tb_next.phase = ~tb_reg.phase;
            tb_next.sample_tick = tb_reg.phase;
         end else begin
            tb_next.col = tb_reg.col + 4'h1;
         end
      end else begin
         tb_next.cnt = tb_reg.cnt + 24'h00_0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tb_reg <= '0;
      end else begin
         tb_reg <= tb_next;
      end
   end

   assign tb.digit_stb = tb_reg.digit_stb;
   assign tb.word_tick = tb_reg.word_tick;
   assign tb.sample_tick = tb_reg.sample_tick;
   assign tb.scan_col = tb_reg.col;
endmodule : bcc_timebase

// >>> testbench/bcc_monitor.sv
// bcc_monitor: ready, cutoff and error display checks at the key control ports
// assumes bound to bcc_key_control; one clock domain
`timescale 1ns/100ps
module bcc_monitor
   import bcc_pkg::*;
#(
   parameter int DIGIT_CYC = DIGIT_CYC_DEF,
   parameter int CUTOFF_WORDS = CUTOFF_WORDS_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ready,
   input wire logic op_req,
   input wire logic [31:0] disp_digits,
   input wire logic [8:0] disp_points,
   input wire logic disp_blank,
   input wire logic err_flag
);
   localparam int WC = 9 * DIGIT_CYC;
   int hi_cnt;
   int lo_cnt;
   int acc_cnt;
   // cycles since ready rose, since it fell, and since the last accept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 0;
         lo_cnt <= 0;
         acc_cnt <= 0;
      end else begin
         hi_cnt <= ready ? hi_cnt + 1 : 0;
         lo_cnt <= ready ? 0 : lo_cnt + 1;
         acc_cnt <= (!ready && lo_cnt == 0) ? 0 : acc_cnt + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_busy_pulse;
      !ready ##1 !op_req;
   endsequence
   AST_ENTRY_WAIT: assert property ($fell(ready) |-> hi_cnt >= 8 * WC)
      else $error("key accepted too early");
   AST_RELEASE_WAIT: assert property ($rose(ready) |-> lo_cnt >= 15 * WC)
      else $error("release ended too early");
   AST_CUTOFF_EARLY: assert property ($rose(disp_blank) |-> acc_cnt >= (CUTOFF_WORDS - 1) * WC)
      else $error("display cut off too early");
   AST_CUTOFF_DUE: assert property (ready && acc_cnt == (CUTOFF_WORDS + 2) * WC |-> disp_blank)
      else $error("display not cut off");
   AST_BLANK_POINTS: assert property (disp_blank |-> disp_points == ALL_POINTS)
      else $error("cutoff without all points");
   AST_UNBLANK: assert property ($fell(disp_blank) |-> !ready)
      else $error("display restored without a key");
   AST_REQ_BUSY: assert property (op_req |-> s_busy_pulse)
      else $error("math request outside a key function");
   AST_ERR_SHOW: assert property (err_flag && !disp_blank |-> disp_digits == REG_RESET && disp_points == ALL_POINTS)
      else $error("error display wrong");
   AST_ERR_CLEAR: assert property ($fell(err_flag) |-> !ready)
      else $error("error cleared without a key");
endmodule : bcc_monitor

// >>> testbench/bcc_partner.sv
// bcc_partner: key matrix and outside math unit facing the key control
// assumes key code = column * 3 + row; answer six cycles after a request
`timescale 1ns/100ps
module bcc_partner
   import bcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] scan_col,
   input wire logic key_down,
   input wire logic [4:0] key,
   input wire logic op_req,
   input wire logic [31:0] ans,
   output logic [2:0] rows,
   output logic op_done,
   output logic [31:0] op_result
);
   logic [3:0] dly;
   // closed switch joins the scanned column to one return line
   assign rows = (key_down && scan_col == 4'(key / 5'h03)) ? 3'(1 << (key % 5'h03)) : 3'h0;
   // junk on the result bus outside the done pulse
   assign op_result = op_done ? ans : ~ans;
   assign op_done = (dly == 4'h1);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly <= 4'h0;
      end else begin
         dly <= op_req ? 4'h6 : ((dly != 4'h0) ? dly - 4'h1 : 4'h0);
      end
   end
endmodule : bcc_partner

// >>> testbench/tb_top.sv
// tb_top: scenario tasks for the key control with keyboard and math partner
// assumes short digit and cutoff counts set below
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("Error %0t: %h %h", $time, a, b); end end
module tb_top
   import bcc_pkg::*;
;
   localparam int DC = 4;
   localparam int CW = 60;
   localparam int WC = 9 * DC;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic key_down = 1'b0;
   logic [4:0] key = 5'h00;
   logic [31:0] ans = 32'h0000_0000;
   logic [2:0] rows;
   logic [3:0] scan_col;
   logic op_req, op_done, ready, disp_blank, err_flag;
   logic [1:0] op_kind;
   logic [31:0] op_result, disp_digits, op_a, op_b;
   logic ovf = 1'b0;
   logic neg = 1'b0;
   logic [8:0] disp_points;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   bcc_key_control #(.DIGIT_CYC(DC), .CUTOFF_WORDS(CW)) dut (.clk, .rst_n, .key_return_line_one(rows[0]),
      .key_return_line_three(rows[1]), .key_return_line_four(rows[2]), .op_done, .op_overflow(ovf),
      .op_neg_base(neg), .op_result, .scan_col, .ready, .op_req, .op_kind, .op_a, .op_b, .disp_digits,
      .disp_points, .disp_blank, .err_flag);
   bcc_partner pm (.clk, .rst_n, .scan_col, .key_down, .key, .op_req, .ans, .rows, .op_done, .op_result);
   task automatic conclude();
      $display("mismatches %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         conclude();
      end
   end
   task automatic wait_rdy(input logic v);
      int n;
      n = 0;
      while (ready !== v && n < 3000) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_rdy
   task automatic press(input logic [4:0] k);
      @(posedge clk);
      #1 key = k;
      key_down = 1'b1;
      wait_rdy(1'b0);
      `CHK(ready, 1'b0)
      repeat (20) @(posedge clk);
      #1 key_down = 1'b0;
      repeat (10 * WC) @(negedge clk);
      `CHK(ready, 1'b0)
      wait_rdy(1'b1);
      `CHK(ready, 1'b1)
   endtask : press
   task automatic t_limit();
      press(5'h01);
      press(KEY_DOT);
      press(5'h02);
      `CHK(disp_digits, 32'h0000_0012)
      press(KEY_DOT);
      `CHK(disp_points, 9'h0_04)
      press(KEY_CLEAR_EVERYTHING);
      repeat (9) press(5'h09);
      `CHK(disp_digits, 32'h9999_9999)
      press(KEY_ADD);
      press(5'h01);
      press(KEY_ADD);
      `CHK(err_flag, 1'b1)
      `CHK(disp_points, ALL_POINTS)
      `CHK(disp_digits, REG_RESET)
      press(5'h03);
      `CHK(err_flag, 1'b0)
   endtask : t_limit
   task automatic t_add();
      press(KEY_CLEAR_EVERYTHING);
      `CHK(disp_digits, REG_RESET)
      press(5'h05);
      press(KEY_ADD);
      press(5'h03);
      press(KEY_ADD);
      `CHK(disp_digits, 32'h0000_0008)
      press(KEY_ADD);
      `CHK(disp_digits, 32'h0000_0011)
      press(5'h05);
      press(KEY_ADD);
      press(5'h04);
      press(KEY_CE);
      press(KEY_ADD);
      `CHK(disp_digits, 32'h0000_0016)
   endtask : t_add
   task automatic t_mul();
      press(KEY_CLEAR_EVERYTHING);
      press(5'h02);
      press(KEY_MUL);
      press(5'h03);
      @(posedge clk) #1 ans = 32'h0000_0006;
      press(KEY_MUL);
      `CHK(disp_digits, 32'h0000_0006)
      `CHK(op_kind, OP_MUL)
      `CHK(op_a, 32'h0000_0002)
      `CHK(op_b, 32'h0000_0003)
      press(5'h04);
      @(posedge clk) #1 ans = 32'h0000_0024;
      press(KEY_EQU);
      `CHK(disp_digits, 32'h0000_0024)
      `CHK(op_b, 32'h0000_0006)
   endtask : t_mul
   task automatic t_idle();
      @(posedge clk);
      #1 key = 5'h07;
      key_down = 1'b1;
      repeat (3 * WC) @(posedge clk);
      #1 key_down = 1'b0;
      repeat (12 * WC) @(negedge clk);
      `CHK(ready, 1'b1)
      `CHK(disp_digits, 32'h0000_0024)
      repeat ((CW + 3) * WC) @(negedge clk);
      `CHK(disp_blank, 1'b1)
      `CHK(disp_points, ALL_POINTS)
      press(5'h01);
      `CHK(disp_blank, 1'b0)
   endtask : t_idle
   task automatic t_err();
      @(posedge clk) #1 ovf = 1'b1;
      press(KEY_EQU);
      @(posedge clk) #1 ovf = 1'b0;
      `CHK(err_flag, 1'b1)
      `CHK(disp_digits, REG_RESET)
      press(5'h02);
      `CHK(err_flag, 1'b0)
      press(KEY_EQU);
      `CHK(op_a, REG_RESET)
      `CHK(op_b, 32'h0000_0006)
      press(5'h03);
      @(posedge clk) #1 neg = 1'b1;
      press(KEY_EXPONENT);
      @(posedge clk) #1 neg = 1'b0;
      `CHK(err_flag, 1'b1)
      `CHK(op_kind, OP_PWR)
      press(5'h01);
      press(KEY_EQU);
      `CHK(op_a, REG_RESET)
      `CHK(op_b, 32'h0000_0003)
   endtask : t_err
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      t_limit();
      t_add();
      t_mul();
      t_idle();
      t_err();
      conclude();
   end
endmodule : tb_top
bind bcc_key_control bcc_monitor #(.DIGIT_CYC(DIGIT_CYC), .CUTOFF_WORDS(CUTOFF_WORDS)) mon (.clk, .rst_n,
   .ready, .op_req, .disp_digits, .disp_points, .disp_blank, .err_flag);
